//--- rtl/cso_defines.svh
// register offsets, status bit positions, reset values and cycle counts
`ifndef CSO_DEFINES_SVH
`define CSO_DEFINES_SVH

`define CSO_OFS_CMD          8'h00
`define CSO_OFS_STAT         8'h04
`define CSO_OFS_SPTR         8'h08
`define CSO_OFS_PC           8'h0C
`define CSO_OFS_RPT          8'h10

`define CSO_WIN_CTRL         2'h0
`define CSO_WIN_DEFAULT_WORK_REG         2'h1
`define CSO_WIN_MEM          2'h2
`define CSO_WIN_STK          2'h3

`define CSO_STAT_WATCHDOG_TIMEOUT_FLAG_BIT    5
`define CSO_STAT_SLEEP_BIT   6

`define CSO_RST_SP           4'h0
`define CSO_DEFAULT_WORK_REG 4'h0

`define CSO_CYC_SINGLE       3'h1
`define CSO_CYC_DOUBLE       3'h2
`define CSO_CYC_RETURN       3'h6
`define CSO_CYC_RETURN_FAST  3'h5

`endif

//--- rtl/cso_pkg.sv
// types shared by the execution slice and its bus front end
package cso_pkg;

    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_NEGATE     = 4'h1,
        OP_PUSH_F     = 4'h2,
        OP_PUSH_W     = 4'h3,
        OP_PUSH_D     = 4'h4,
        OP_PUSH_S     = 4'h5,
        OP_POP_F      = 4'h6,
        OP_POP_W      = 4'h7,
        OP_POP_D      = 4'h8,
        OP_POP_S      = 4'h9,
        OP_REPEAT_LIT = 4'hA,
        OP_REPEAT_REG = 4'hB,
        OP_LOW_POWER  = 4'hC,
        OP_RETURN_LIT = 4'hD,
        OP_ROTATE_LC  = 4'hE
    } cso_op_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_RUN    = 3'b010,
        ST_LOWPWR = 3'b100
    } cso_phase_t;

    typedef struct packed {
        logic [1:0]  rsvd;
        logic        fast;
        logic [14:0] lit;
        logic [3:0]  dst;
        logic [3:0]  src;
        logic        to_default_work_reg;
        logic        reg_form;
        cso_op_t     op;
    } cso_cmd_t;

    typedef struct packed {
        logic digit_carry_flag;
        logic negative;
        logic overflow_flag;
        logic zero;
        logic carry;
    } cso_flags_t;

    typedef struct packed {
        logic        wr_ph;
        logic        rd_ph;
        logic        rd_done;
        logic [7:0]  addr;
        logic [31:0] rdata;
    } cso_bus_st_t;

    typedef struct packed {
        cso_phase_t        phase;
        logic [2:0]        cnt;
        cso_cmd_t          cmd;
        logic [15:0][15:0] w;
        logic [15:0][15:0] mem;
        logic [15:0][15:0] stk;
        logic [3:0]        sp;
        logic [15:0]       pc;
        cso_flags_t        fl;
        cso_flags_t        sh_fl;
        logic [3:0][15:0]  sh_w;
        logic              rpt_on;
        logic [15:0]       rpt_left;
        logic              watchdog_timeout_flag;
        logic              slp;
    } cso_core_st_t;

endpackage : cso_pkg

//--- rtl/cso_alu.sv
// negate and rotate-left-through-carry datapath with flag results
`timescale 1ns/1ps
module cso_alu (
    input  wire logic              negate,
    input  wire logic [15:0]       value,
    input  wire logic              carry_in,
    output logic [15:0]            result,
    output cso_pkg::cso_flags_t    flags
);
    always_comb begin
        if (negate) begin
            result                 = ~value + 16'h0001;
            flags.carry            = (value == 16'h0000);
            flags.digit_carry_flag = (value[3:0] == 4'h0);
            flags.overflow_flag    = (value == 16'h8000);
        end else begin
            result                 = {value[14:0], carry_in};
            flags.carry            = value[15];
            flags.digit_carry_flag = 1'b0;
            flags.overflow_flag    = 1'b0;
        end
        flags.negative = result[15];
        flags.zero     = (result == 16'h0000);
    end
endmodule : cso_alu

//--- rtl/cso_ahb_slave.sv
// ahb-lite slave front end: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module cso_ahb_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] rd_data,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             wr_en,
    output logic [7:0]       acc_addr,
    output logic [31:0]      wr_data
);
    cso_pkg::cso_bus_st_t st_ff;
    cso_pkg::cso_bus_st_t nxt_st;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.wr_ph = 1'b0;
        if (st_ff.rd_ph && !st_ff.rd_done) begin
            // first data-phase cycle of a read: capture the word
            nxt_st.rdata   = rd_data;
            nxt_st.rd_done = 1'b1;
        end else begin
            nxt_st.rd_ph   = 1'b0;
            nxt_st.rd_done = 1'b0;
            if (hsel && htrans[1] && hready) begin
                nxt_st.addr  = haddr[7:0];
                nxt_st.wr_ph = hwrite;
                nxt_st.rd_ph = !hwrite;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign hreadyout = !(st_ff.rd_ph && !st_ff.rd_done);
    assign hrdata    = st_ff.rdata;
    assign hresp     = 1'b0;
    assign wr_en     = st_ff.wr_ph;
    assign acc_addr  = st_ff.addr;
    assign wr_data   = hwdata;
endmodule : cso_ahb_slave

//--- rtl/cso_core.sv
// execution slice: negate, stack, repeat, low power, literal return, rotate
// Notes on behaviour
// - negate writes inverse plus one to destination in one cycle, sets five flags
// - push of a memory word puts it on stack top, one cycle, flags kept
// - pop to memory takes stack top into that word, one cycle, flags kept
// - pop to a working register loads the chosen register, one cycle, flags kept
// - double push and pop move registers n and n+1, two cycles, flags kept
// - literal repeat runs the next command literal plus one times; itself one cycle
// - register repeat runs the next command register value plus one times
// - low power literal picks sleep or idle, clears watchdog status, sets sleep status for sleep only
// - literal return loads ten-bit literal, pops caller, six cycles or five
// - rotate left through carry on memory writes back, updates carry, negative, zero
// - rotate to default work register leaves the memory word unchanged
// - register form rotates source register into a separate destination register
`timescale 1ns/1ps
`include "cso_defines.svh"
module cso_core (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire logic        wake,
    input  wire logic        wdt_timeout,
    output logic             sleep_mode,
    output logic             idle_mode,
    output logic             busy
);
    cso_pkg::cso_core_st_t st_ff;
    cso_pkg::cso_core_st_t nxt_st;
    cso_pkg::cso_cmd_t     cmd;
    cso_pkg::cso_cmd_t     wcmd;
    cso_pkg::cso_flags_t   alu_fl;
    logic [15:0]           alu_res;
    logic [15:0]           operand;
    logic                  opnd_top;
    logic [15:0]           stack_top;
    logic [15:0]           src_reg;
    logic [2:0]            need;
    logic                  run;
    logic                  last;
    logic                  accept;
    logic                  wr_en;
    logic [7:0]            acc_addr;
    logic [31:0]           wr_data;
    logic [31:0]           rd_data;
    logic [10:0]           stat_word;

    cso_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .rd_data   (rd_data),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .wr_en     (wr_en),
        .acc_addr  (acc_addr),
        .wr_data   (wr_data)
    );

    cso_alu u_alu (
        .negate   (cmd.op == cso_pkg::OP_NEGATE),
        .value    (operand),
        .carry_in (st_ff.fl.carry),
        .result   (alu_res),
        .flags    (alu_fl)
    );

    assign cmd       = st_ff.cmd;
    assign wcmd      = cso_pkg::cso_cmd_t'(wr_data);
    assign run       = (st_ff.phase == cso_pkg::ST_RUN);
    assign src_reg   = st_ff.w[cmd.src];
    assign operand   = cmd.reg_form ? src_reg : st_ff.mem[cmd.src];
    assign opnd_top  = operand[15];
    assign stack_top = st_ff.stk[st_ff.sp - 4'h1];
    assign accept    = wr_en && (acc_addr == `CSO_OFS_CMD) && (st_ff.phase == cso_pkg::ST_IDLE);
    assign last      = run && (st_ff.cnt == need - 3'h1);

    // cycles each command occupies
    always_comb begin
        case (cmd.op)
            cso_pkg::OP_PUSH_D,
            cso_pkg::OP_POP_D:      need = `CSO_CYC_DOUBLE;
            cso_pkg::OP_RETURN_LIT: need = cmd.fast ? `CSO_CYC_RETURN_FAST : `CSO_CYC_RETURN;
            default:                need = `CSO_CYC_SINGLE;
        endcase
    end

    always_comb begin
        nxt_st = st_ff;
        // software writes to state only while no command runs
        if (wr_en && !run) begin
            case (acc_addr[7:6])
                `CSO_WIN_CTRL: begin
                    case (acc_addr)
                        `CSO_OFS_STAT: begin
                            nxt_st.fl = cso_pkg::cso_flags_t'(wr_data[4:0]);
                            if (wr_data[`CSO_STAT_WATCHDOG_TIMEOUT_FLAG_BIT]) begin
                                nxt_st.watchdog_timeout_flag = 1'b0;
                            end
                            if (wr_data[`CSO_STAT_SLEEP_BIT]) begin
                                nxt_st.slp = 1'b0;
                            end
                        end
                        `CSO_OFS_SPTR: nxt_st.sp = wr_data[3:0];
                        `CSO_OFS_PC:   nxt_st.pc = wr_data[15:0];
                        default: ;
                    endcase
                end
                `CSO_WIN_DEFAULT_WORK_REG: nxt_st.w[acc_addr[5:2]] = wr_data[15:0];
                `CSO_WIN_MEM:  nxt_st.mem[acc_addr[5:2]] = wr_data[15:0];
                default: ;
            endcase
        end
        case (st_ff.phase)
            cso_pkg::ST_IDLE: begin
                if (accept) begin
                    nxt_st.cmd   = wcmd;
                    nxt_st.cnt   = 3'h0;
                    nxt_st.phase = cso_pkg::ST_RUN;
                end
            end
            cso_pkg::ST_RUN: begin
                nxt_st.cnt = st_ff.cnt + 3'h1;
                case (cmd.op)
                    cso_pkg::OP_NEGATE,
                    cso_pkg::OP_ROTATE_LC: begin
                        if (cmd.reg_form) begin
                            nxt_st.w[cmd.dst] = alu_res;
                        end else if (cmd.to_default_work_reg) begin
                            nxt_st.w[`CSO_DEFAULT_WORK_REG] = alu_res;
                        end else begin
                            nxt_st.mem[cmd.src] = alu_res;
                        end
                        if (cmd.op == cso_pkg::OP_NEGATE) begin
                            nxt_st.fl = alu_fl;
                        end else begin
                            nxt_st.fl.carry    = alu_fl.carry;
                            nxt_st.fl.negative = alu_fl.negative;
                            nxt_st.fl.zero     = alu_fl.zero;
                        end
                    end
                    cso_pkg::OP_PUSH_F: begin
                        nxt_st.stk[st_ff.sp] = st_ff.mem[cmd.src];
                        nxt_st.sp            = st_ff.sp + 4'h1;
                    end
                    cso_pkg::OP_PUSH_W: begin
                        nxt_st.stk[st_ff.sp] = src_reg;
                        nxt_st.sp            = st_ff.sp + 4'h1;
                    end
                    cso_pkg::OP_PUSH_D: begin
                        // register n first, then n+1
                        nxt_st.stk[st_ff.sp] = st_ff.w[cmd.src + 4'(st_ff.cnt)];
                        nxt_st.sp            = st_ff.sp + 4'h1;
                    end
                    cso_pkg::OP_POP_F: begin
                        nxt_st.mem[cmd.src] = stack_top;
                        nxt_st.sp           = st_ff.sp - 4'h1;
                    end
                    cso_pkg::OP_POP_W: begin
                        nxt_st.w[cmd.dst] = stack_top;
                        nxt_st.sp         = st_ff.sp - 4'h1;
                    end
                    cso_pkg::OP_POP_D: begin
                        // reverse order: n+1 comes off first
                        nxt_st.w[cmd.dst + ((st_ff.cnt == 3'h0) ? 4'h1 : 4'h0)] = stack_top;
                        nxt_st.sp = st_ff.sp - 4'h1;
                    end
                    cso_pkg::OP_PUSH_S: begin
                        nxt_st.sh_w  = st_ff.w[3:0];
                        nxt_st.sh_fl = st_ff.fl;
                    end
                    cso_pkg::OP_POP_S: begin
                        nxt_st.w[3:0] = st_ff.sh_w;
                        nxt_st.fl     = st_ff.sh_fl;
                    end
                    cso_pkg::OP_REPEAT_LIT: begin
                        nxt_st.rpt_on   = 1'b1;
                        nxt_st.rpt_left = {1'b0, cmd.lit};
                    end
                    cso_pkg::OP_REPEAT_REG: begin
                        nxt_st.rpt_on   = 1'b1;
                        nxt_st.rpt_left = src_reg;
                    end
                    cso_pkg::OP_LOW_POWER: begin
                        nxt_st.watchdog_timeout_flag = 1'b0;
                        if (!cmd.lit[0]) begin
                            nxt_st.slp = 1'b1;
                        end
                    end
                    cso_pkg::OP_RETURN_LIT: begin
                        if (st_ff.cnt == 3'h0) begin
                            nxt_st.w[cmd.dst] = {6'h00, cmd.lit[9:0]};
                            nxt_st.pc         = stack_top;
                            nxt_st.sp         = st_ff.sp - 4'h1;
                        end
                    end
                    default: ;
                endcase
                if (last) begin
                    if (cmd.op == cso_pkg::OP_REPEAT_LIT || cmd.op == cso_pkg::OP_REPEAT_REG) begin
                        nxt_st.phase = cso_pkg::ST_IDLE;
                    end else if (st_ff.rpt_on && st_ff.rpt_left != 16'h0000) begin
                        // run the same command again
                        nxt_st.rpt_left = st_ff.rpt_left - 16'h0001;
                        nxt_st.cnt      = 3'h0;
                    end else begin
                        nxt_st.rpt_on = 1'b0;
                        nxt_st.phase  = (cmd.op == cso_pkg::OP_LOW_POWER) ? cso_pkg::ST_LOWPWR
                                                                           : cso_pkg::ST_IDLE;
                    end
                end
            end
            cso_pkg::ST_LOWPWR: begin
                if (wake || wdt_timeout) begin
                    nxt_st.phase = cso_pkg::ST_IDLE;
                end
            end
            default: nxt_st.phase = cso_pkg::ST_IDLE;
        endcase
        // timeout wins over any clear in the same cycle
        if (wdt_timeout) begin
            nxt_st.watchdog_timeout_flag = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff       <= '0;
            st_ff.phase <= cso_pkg::ST_IDLE;
            st_ff.sp    <= `CSO_RST_SP;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign stat_word = {cmd.lit[0] && (st_ff.phase == cso_pkg::ST_LOWPWR),
                        st_ff.phase == cso_pkg::ST_LOWPWR,
                        st_ff.rpt_on, run, st_ff.slp, st_ff.watchdog_timeout_flag, st_ff.fl};

    // read mux, sampled by the bus front end one cycle into the data phase
    always_comb begin
        rd_data = 32'h0000_0000;
        case (acc_addr[7:6])
            `CSO_WIN_CTRL: begin
                case (acc_addr)
                    `CSO_OFS_CMD:  rd_data = cmd;
                    `CSO_OFS_STAT: rd_data = {21'h000000, stat_word};
                    `CSO_OFS_SPTR: rd_data = {28'h0000000, st_ff.sp};
                    `CSO_OFS_PC:   rd_data = {16'h0000, st_ff.pc};
                    `CSO_OFS_RPT:  rd_data = {16'h0000, st_ff.rpt_left};
                    default:       rd_data = 32'h0000_0000;
                endcase
            end
            `CSO_WIN_DEFAULT_WORK_REG: rd_data = {16'h0000, st_ff.w[acc_addr[5:2]]};
            `CSO_WIN_MEM:  rd_data = {16'h0000, st_ff.mem[acc_addr[5:2]]};
            default:       rd_data = {16'h0000, st_ff.stk[acc_addr[5:2]]};
        endcase
    end

    assign sleep_mode = (st_ff.phase == cso_pkg::ST_LOWPWR) && !cmd.lit[0];
    assign idle_mode  = (st_ff.phase == cso_pkg::ST_LOWPWR) && cmd.lit[0];
    assign busy       = run;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    negate_mem_a:
    assert property ((run && cmd.op == cso_pkg::OP_NEGATE && !cmd.reg_form && !cmd.to_default_work_reg)
        |=> (st_ff.mem[$past(cmd.src)] == 16'(~$past(operand) + 16'h0001))
            && (st_ff.fl.carry == ($past(operand) == 16'h0000)))
        else $error("negate result or carry wrong");

    push_keeps_flags_a:
    assert property ((run && cmd.op == cso_pkg::OP_PUSH_F)
        |=> (st_ff.fl == $past(st_ff.fl)) && (st_ff.sp == 4'($past(st_ff.sp) + 4'h1)))
        else $error("push changed flags or pointer wrong");

    pop_mem_a:
    assert property ((run && cmd.op == cso_pkg::OP_POP_F)
        |=> (st_ff.mem[$past(cmd.src)] == $past(stack_top)) && (st_ff.fl == $past(st_ff.fl)))
        else $error("pop to memory wrong");

    pop_reg_a:
    assert property ((run && cmd.op == cso_pkg::OP_POP_W)
        |=> (st_ff.w[$past(cmd.dst)] == $past(stack_top)) && (st_ff.fl == $past(st_ff.fl)))
        else $error("pop to register wrong");

    double_push_a:
    assert property ((run && cmd.op == cso_pkg::OP_PUSH_D && st_ff.cnt == 3'h0)
        |=> run ##1 (st_ff.sp == 4'($past(st_ff.sp, 2) + 4'h2)))
        else $error("double push not two words in two cycles");

    repeat_lit_a:
    assert property ((run && cmd.op == cso_pkg::OP_REPEAT_LIT)
        |=> st_ff.rpt_on && (st_ff.rpt_left == {1'b0, $past(cmd.lit)}) && !run)
        else $error("literal repeat not armed");

    repeat_reg_a:
    assert property ((run && cmd.op == cso_pkg::OP_REPEAT_REG)
        |=> st_ff.rpt_on && (st_ff.rpt_left == $past(src_reg)))
        else $error("register repeat not armed");

    sleep_entry_a:
    assert property ((last && cmd.op == cso_pkg::OP_LOW_POWER && !cmd.lit[0] && !st_ff.rpt_on && !wdt_timeout)
        |=> sleep_mode && st_ff.slp && !st_ff.watchdog_timeout_flag)
        else $error("sleep entry wrong");

    return_time_a:
    assert property ((accept && wcmd.op == cso_pkg::OP_RETURN_LIT && !wcmd.fast && !st_ff.rpt_on)
        |=> run [*6] ##1 (st_ff.phase == cso_pkg::ST_IDLE))
        else $error("literal return not six cycles");

    rotate_mem_a:
    assert property ((run && cmd.op == cso_pkg::OP_ROTATE_LC && !cmd.reg_form && !cmd.to_default_work_reg)
        |=> (st_ff.mem[$past(cmd.src)] == (16'($past(operand) << 1) | 16'($past(st_ff.fl.carry))))
            && (st_ff.fl.carry == $past(opnd_top)))
        else $error("rotate on memory wrong");

    rotate_default_work_reg_a:
    assert property ((run && cmd.op == cso_pkg::OP_ROTATE_LC && !cmd.reg_form && cmd.to_default_work_reg
                      && cmd.src != `CSO_DEFAULT_WORK_REG)
        |=> (st_ff.mem[$past(cmd.src)] == $past(operand))
            && (st_ff.w[`CSO_DEFAULT_WORK_REG] == (16'($past(operand) << 1) | 16'($past(st_ff.fl.carry)))))
        else $error("rotate to default register wrong");

    rotate_reg_a:
    assert property ((run && cmd.op == cso_pkg::OP_ROTATE_LC && cmd.reg_form)
        |=> st_ff.w[$past(cmd.dst)] == (16'($past(operand) << 1) | 16'($past(st_ff.fl.carry))))
        else $error("register rotate wrong");

    shadow_pop_a:
    assert property ((run && cmd.op == cso_pkg::OP_POP_S)
        |=> (st_ff.fl == $past(st_ff.sh_fl)) && (st_ff.w[3:0] == $past(st_ff.sh_w)))
        else $error("shadow restore wrong");

    double_pop_c: cover property (run && cmd.op == cso_pkg::OP_POP_D ##1 run);
    repeat_run_c: cover property (last && st_ff.rpt_on && st_ff.rpt_left != 16'h0000);
    wake_c:       cover property ((st_ff.phase == cso_pkg::ST_LOWPWR) ##1 (st_ff.phase == cso_pkg::ST_IDLE));
endmodule : cso_core

//--- verification/cso_core_test.sv
// self-checking bench for the execution slice over its ahb-lite port
`timescale 1ns/1ps
module cso_core_test;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        wake, wdt_timeout, sleep_mode, idle_mode, busy;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_errors = 0;
    int          n_tests  = 0;
    int          nb       = 0;
    assign hready = hreadyout;
    cso_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .wake(wake), .wdt_timeout(wdt_timeout),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode), .busy(busy));
    initial begin
        hclk = 0;
        forever #2 hclk = ~hclk;
    end
    always @(negedge hclk) if (busy === 1'b1) nb <= nb + 1;
    task stop_test;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    task chk(input string n, input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // waits for hready high; data taken at that edge
    task rdy(output logic [31:0] d);
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge hclk);
            if (hreadyout === 1'b1) break;
        end
        d = hrdata;
        if (k == 40) begin
            n_errors++;
            stop_test;
        end
        @(posedge hclk);
    endtask : rdy
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        rdy(r);
        htrans <= 2'h0;
        hwdata <= d;
        rdy(r);
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task rc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), r, e);
        chk("response", {31'h0, hresp}, 32'h0);
    endtask : rc
    task wbusy;
        int k;
        for (k = 0; k < 100; k++) begin
            @(negedge hclk);
            if (busy === 1'b0) break;
        end
        if (k == 100) begin
            n_errors++;
            stop_test;
        end
        @(posedge hclk);
    endtask : wbusy
    function automatic logic [31:0] cw(logic [3:0] op, logic rf, logic tw, logic [3:0] s, logic [3:0] d,
                                       logic [14:0] l, logic f);
        return {2'h0, f, l, d, s, tw, rf, op};
    endfunction : cw
    // starts a command and counts its busy cycles
    task run(input logic [31:0] c, input int n);
        int s;
        s = nb;
        wr(8'h00, c);
        wbusy;
        chk("busy cycles", 32'(nb - s), 32'(n));
    endtask : run
    task pins(input logic s, input logic i);
        @(negedge hclk);
        chk("low power pins", {30'h0, sleep_mode, idle_mode}, {30'h0, s, i});
        @(posedge hclk);
    endtask : pins
    initial begin
        {hresetn, hsel, hwrite, wake, wdt_timeout} = 5'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rc(8'h04, 32'h0);
        rc(8'h20, 32'h0);
        wr(8'h80, 32'h0001);
        run(cw(4'h1, 0, 0, 0, 0, 15'h0, 0), 1);
        rc(8'h80, 32'hFFFF);
        rc(8'h04, 32'h08);
        wr(8'h44, 32'h8000);
        run(cw(4'h1, 1, 0, 1, 2, 15'h0, 0), 1);
        rc(8'h48, 32'h8000);
        rc(8'h04, 32'h1C);
        wr(8'h04, 32'h01);
        wr(8'h84, 32'h8001);
        run(cw(4'hE, 0, 0, 1, 0, 15'h0, 0), 1);
        rc(8'h84, 32'h0003);
        rc(8'h04, 32'h01);
        run(cw(4'hE, 0, 1, 1, 0, 15'h0, 0), 1);
        rc(8'h40, 32'h0007);
        rc(8'h84, 32'h0003);
        rc(8'h04, 32'h00);
        run(cw(4'hE, 1, 0, 1, 7, 15'h0, 0), 1);
        rc(8'h5C, 32'h0000);
        rc(8'h44, 32'h8000);
        rc(8'h04, 32'h03);
        wr(8'h88, 32'h1234);
        run(cw(4'h2, 0, 0, 2, 0, 15'h0, 0), 1);
        rc(8'hC0, 32'h1234);
        run(cw(4'h3, 0, 0, 1, 0, 15'h0, 0), 1);
        run(cw(4'h7, 0, 0, 0, 8, 15'h0, 0), 1);
        rc(8'h60, 32'h8000);
        run(cw(4'h6, 0, 0, 3, 0, 15'h0, 0), 1);
        rc(8'h8C, 32'h1234);
        rc(8'h08, 32'h0);
        rc(8'h04, 32'h03);
        wr(8'h48, 32'h00A5);
        run(cw(4'h4, 0, 0, 1, 0, 15'h0, 0), 2);
        rc(8'hC4, 32'h00A5);
        run(cw(4'h8, 0, 0, 0, 4, 15'h0, 0), 2);
        rc(8'h50, 32'h8000);
        rc(8'h54, 32'h00A5);
        rc(8'h04, 32'h03);
        wr(8'h80, 32'hFFFF);
        run(cw(4'hA, 0, 0, 0, 0, 15'h2, 0), 1);
        run(cw(4'h1, 0, 0, 0, 0, 15'h0, 0), 3);
        rc(8'h80, 32'h0001);
        wr(8'h4C, 32'h0001);
        run(cw(4'hB, 0, 0, 3, 0, 15'h0, 0), 1);
        run(cw(4'h3, 0, 0, 2, 0, 15'h0, 0), 2);
        rc(8'h08, 32'h2);
        wr(8'h08, 32'h0);
        run(cw(4'h3, 0, 0, 2, 0, 15'h0, 0), 1);
        run(cw(4'hD, 0, 0, 0, 6, 15'h02A5, 0), 6);
        rc(8'h58, 32'h02A5);
        rc(8'h0C, 32'h00A5);
        run(cw(4'h3, 0, 0, 1, 0, 15'h0, 0), 1);
        run(cw(4'hD, 0, 0, 0, 6, 15'h7D55, 1), 5);
        rc(8'h58, 32'h0155);
        rc(8'h0C, 32'h8000);
        wr(8'h04, 32'h03);
        run(cw(4'h5, 0, 0, 0, 0, 15'h0, 0), 1);
        wr(8'h40, 32'hBEEF);
        wr(8'h04, 32'h1C);
        run(cw(4'h9, 0, 0, 0, 0, 15'h0, 0), 1);
        rc(8'h40, 32'h0007);
        rc(8'h04, 32'h03);
        run(cw(4'hC, 0, 0, 0, 0, 15'h0, 0), 1);
        pins(1'b1, 1'b0);
        wake <= 1'b1;
        @(posedge hclk);
        wake <= 1'b0;
        pins(1'b0, 1'b0);
        rc(8'h04, 32'h43);
        run(cw(4'hC, 0, 0, 0, 0, 15'h1, 0), 1);
        pins(1'b0, 1'b1);
        rc(8'h04, 32'h643);
        wdt_timeout <= 1'b1;
        @(posedge hclk);
        wdt_timeout <= 1'b0;
        pins(1'b0, 1'b0);
        rc(8'h04, 32'h63);
        wr(8'h04, 32'h63);
        rc(8'h04, 32'h03);
        stop_test;
    end
endmodule : cso_core_test
